/* core/hto_pkg.sv */
// Package: register map, field positions, reset values and on-hook timing constants
package hto_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_TAP_SEVEN = 8'h33;
  localparam logic [7:0] ADDR_TAP_EIGHT = 8'h34;
  localparam logic [7:0] ADDR_RSVD_FIRST = 8'h35;
  localparam logic [7:0] ADDR_RSVD_LAST = 8'h3A;
  localparam logic [7:0] ADDR_QUENCH_CTRL = 8'h3B;

  // Field positions in the on-hook speed control register
  localparam int unsigned QUENCH_HI_BIT = 6;
  localparam int unsigned QUENCH_LO_BIT = 4;

  // Reset values
  localparam logic [7:0] TAP_RESET = 8'h00;
  localparam logic QUENCH_RESET = 1'b0;

  // Clock and on-hook times
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ONHOOK_FAST_NS = 500000;
  localparam int unsigned ONHOOK_ETSI_NS = 3000000;
  localparam int unsigned ONHOOK_QUENCH_NS = 26000000;
  // Fast setting must stay strictly below its bound, so one cycle is taken off
  localparam int unsigned ONHOOK_FAST_CYC = ONHOOK_FAST_NS / CLK_PERIOD_NS - 1;
  localparam int unsigned ONHOOK_ETSI_CYC = ONHOOK_ETSI_NS / CLK_PERIOD_NS;
  localparam int unsigned ONHOOK_QUENCH_CYC = ONHOOK_QUENCH_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 22;

  // Line state
  typedef enum logic [1:0] {
    HTO_IDLE,
    HTO_SEIZED,
    HTO_RELEASE
  } hto_line_t;

endpackage

/* core/hto_regs.sv */
// Hybrid taps seven and eight, reserved block and on-hook speed control registers

////////////////////////////////////////////////////////////////////////////////
module hto_regs #(
  parameter int unsigned FAST_CYC = hto_pkg::ONHOOK_FAST_CYC,
  parameter int unsigned ETSI_CYC = hto_pkg::ONHOOK_ETSI_CYC,
  parameter int unsigned QUENCH_CYC = hto_pkg::ONHOOK_QUENCH_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic line_seize_ctrl_i,
  input wire logic onhook_speed_sel_i,
  input wire logic onhook_speed_sel_b_i,
  output logic [7:0] tap_seven_coeff_o,
  output logic [7:0] tap_eight_coeff_o,
  output logic tap_seven_active_o,
  output logic tap_eight_active_o,
  output logic [1:0] quench_sel_o,
  output logic loop_current_on_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r;
  logic rst_n_r;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] tap_seven_coeff_r;
  logic [7:0] tap_eight_coeff_r;
  logic quench_sel_hi_r;
  logic quench_sel_lo_r;
  logic wr_seven;
  logic wr_eight;
  logic wr_quench;

  // Write decode; reserved addresses accept nothing
  assign wr_seven = reg_wr_i && (reg_addr_i == hto_pkg::ADDR_TAP_SEVEN);
  assign wr_eight = reg_wr_i && (reg_addr_i == hto_pkg::ADDR_TAP_EIGHT);
  assign wr_quench = reg_wr_i && (reg_addr_i == hto_pkg::ADDR_QUENCH_CTRL);

  // Tap coefficients
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tap_seven_coeff_r <= hto_pkg::TAP_RESET;
      tap_eight_coeff_r <= hto_pkg::TAP_RESET;
    end else begin
      if (wr_seven) begin
        tap_seven_coeff_r <= reg_wdata_i;
      end
      if (wr_eight) begin
        tap_eight_coeff_r <= reg_wdata_i;
      end
    end
  end

  // Quench field; other bits of this register are not stored and read zero
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      quench_sel_hi_r <= hto_pkg::QUENCH_RESET;
      quench_sel_lo_r <= hto_pkg::QUENCH_RESET;
    end else if (wr_quench) begin
      quench_sel_hi_r <= reg_wdata_i[hto_pkg::QUENCH_HI_BIT];
      quench_sel_lo_r <= reg_wdata_i[hto_pkg::QUENCH_LO_BIT];
    end
  end

  assign tap_seven_coeff_o = tap_seven_coeff_r;
  assign tap_eight_coeff_o = tap_eight_coeff_r;
  assign quench_sel_o = {quench_sel_hi_r, quench_sel_lo_r};

  // A zero coefficient switches its filter stage off
  assign tap_seven_active_o = |tap_seven_coeff_r;
  assign tap_eight_active_o = |tap_eight_coeff_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] rdata_nxt;

  // Read mux; reserved and unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr_i)
      hto_pkg::ADDR_TAP_SEVEN: rdata_nxt = tap_seven_coeff_r;
      hto_pkg::ADDR_TAP_EIGHT: rdata_nxt = tap_eight_coeff_r;
      hto_pkg::ADDR_QUENCH_CTRL: begin
        rdata_nxt[hto_pkg::QUENCH_HI_BIT] = quench_sel_hi_r;
        rdata_nxt[hto_pkg::QUENCH_LO_BIT] = quench_sel_lo_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // On-hook release timing

  hto_pkg::hto_line_t line_r;
  logic [hto_pkg::CNT_W-1:0] cnt_r;
  logic [hto_pkg::CNT_W-1:0] limit_nxt;

  // Speed select: slow quench setting first, then the 3 ms setting, else fast
  always_comb begin
    if (onhook_speed_sel_i && quench_sel_hi_r && quench_sel_lo_r) begin
      limit_nxt = hto_pkg::CNT_W'(QUENCH_CYC);
    end else if (onhook_speed_sel_b_i && !onhook_speed_sel_i) begin
      limit_nxt = hto_pkg::CNT_W'(ETSI_CYC);
    end else begin
      limit_nxt = hto_pkg::CNT_W'(FAST_CYC);
    end
  end

  // Loop current stays on through the release time after the seize bit clears
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      line_r <= hto_pkg::HTO_IDLE;
      cnt_r <= '0;
    end else begin
      case (line_r)
        hto_pkg::HTO_IDLE: begin
          if (line_seize_ctrl_i) begin
            line_r <= hto_pkg::HTO_SEIZED;
          end
        end
        hto_pkg::HTO_SEIZED: begin
          if (!line_seize_ctrl_i) begin
            line_r <= hto_pkg::HTO_RELEASE;
            cnt_r <= limit_nxt - 1'b1;
          end
        end
        hto_pkg::HTO_RELEASE: begin
          if (line_seize_ctrl_i) begin
            line_r <= hto_pkg::HTO_SEIZED;
          end else if (cnt_r == '0) begin
            line_r <= hto_pkg::HTO_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: line_r <= hto_pkg::HTO_IDLE;
      endcase
    end
  end

  assign loop_current_on_o = (line_r != hto_pkg::HTO_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence seq_release_start;
    line_r == hto_pkg::HTO_SEIZED && !line_seize_ctrl_i;
  endsequence

  sequence seq_release_end;
    line_r == hto_pkg::HTO_RELEASE && !line_seize_ctrl_i && cnt_r == '0;
  endsequence

  chk_tap_seven_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    wr_seven |=> tap_seven_coeff_o == $past(reg_wdata_i))
    else $error("tap seven coefficient not written");

  chk_tap_eight_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    wr_eight |=> tap_eight_coeff_o == $past(reg_wdata_i))
    else $error("tap eight coefficient not written");

  chk_tap_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    reg_rd_i && reg_addr_i == hto_pkg::ADDR_TAP_SEVEN && !reg_wr_i
    |=> reg_rvalid_o && reg_rdata_o == tap_seven_coeff_o)
    else $error("tap seven readback wrong");

  chk_stage_zero_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    (tap_seven_coeff_o == 8'h00) == !tap_seven_active_o &&
    (tap_eight_coeff_o == 8'h00) == !tap_eight_active_o)
    else $error("zero tap stage still active");

  chk_release_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    seq_release_start |=> cnt_r == $past(limit_nxt) - 1'b1 && loop_current_on_o)
    else $error("release time not loaded from speed select");

  chk_quench_select: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    onhook_speed_sel_i && quench_sel_o == 2'h3
    |-> limit_nxt == hto_pkg::CNT_W'(QUENCH_CYC))
    else $error("slow quench setting not selected");

  chk_current_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    seq_release_end |=> !loop_current_on_o)
    else $error("loop current not dropped at end of release");

  chk_no_early_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    $fell(loop_current_on_o) |-> $past(line_r) == hto_pkg::HTO_RELEASE && $past(cnt_r) == '0)
    else $error("loop current dropped early");

  chk_quench_lo_pos: assert property (@(posedge clk_sys_i) disable iff (!rst_n_r)
    wr_quench |=> quench_sel_o == {$past(reg_wdata_i[6]), $past(reg_wdata_i[4])})
    else $error("quench field bits misplaced");

endmodule

/* test/tb_top.sv */
// Self-checking bench for the hybrid tap and on-hook speed registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int F_CYC = 5;
  localparam int E_CYC = 10;
  localparam int Q_CYC = 20;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic seize_i = 1'b0;
  logic spd_i = 1'b0;
  logic spd_b_i = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] tap7;
  logic [7:0] tap8;
  logic act7;
  logic act8;
  logic [1:0] quench;
  logic current;
  logic [23:0] rows [7] = '{24'h33A5A5, 24'h345A5A, 24'h3B7F50, 24'h3B2F00, 24'h3B1010,
                            24'h00FF00, 24'h330000};
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  hto_regs #(.FAST_CYC(F_CYC), .ETSI_CYC(E_CYC), .QUENCH_CYC(Q_CYC)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .line_seize_ctrl_i(seize_i),
    .onhook_speed_sel_i(spd_i), .onhook_speed_sel_b_i(spd_b_i),
    .tap_seven_coeff_o(tap7), .tap_eight_coeff_o(tap8), .tap_seven_active_o(act7),
    .tap_eight_active_o(act8), .quench_sel_o(quench), .loop_current_on_o(current));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // Register read, answer checked one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("read valid", 8'h01, {7'h00, rvalid});
    chk(what, e, rdata);
  endtask

  // Seize, then release and time the fall of loop current
  task automatic hook(input logic s, input logic sb, input logic [7:0] q, input int n);
    int cnt;
    wr(8'h3B, q);
    @(posedge clk_sys_i);
    spd_i <= s;
    spd_b_i <= sb;
    seize_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("current on", 8'h01, {7'h00, current});
    chk("quench field", {6'h00, q[6], q[4]}, {6'h00, quench});
    @(posedge clk_sys_i);
    seize_i <= 1'b0;
    cnt = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
    end while (current === 1'b1 && cnt < 100);
    chk("onhook window", 8'h01, {7'h00, cnt >= n + 1 && cnt <= n + 3});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    @(posedge clk_sys_i);
    #1;
    chk("tap seven in reset", 8'h00, tap7);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(8'h33, 8'h00, "tap seven reset");
    rd(8'h34, 8'h00, "tap eight reset");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0], "readback");
    end
    chk("tap seven active", 8'h00, {7'h00, act7});
    wr(8'h33, 8'h80);
    #1;
    chk("tap seven coeff", 8'h80, tap7);
    chk("tap seven active", 8'h01, {7'h00, act7});
    wr(8'h34, 8'h01);
    #1;
    chk("tap eight coeff", 8'h01, tap8);
    chk("tap eight active", 8'h01, {7'h00, act8});
    wr(8'h34, 8'h00);
    #1;
    chk("tap eight active", 8'h00, {7'h00, act8});
    rd(8'h35, 8'h00, "reserved first");
    rd(8'h3A, 8'h00, "reserved last");
    hook(1'b0, 1'b0, 8'h00, F_CYC);
    hook(1'b0, 1'b1, 8'h00, E_CYC);
    hook(1'b1, 1'b0, 8'h50, Q_CYC);
    hook(1'b1, 1'b1, 8'h50, Q_CYC);
    // Seizing again during the release keeps loop current on
    @(posedge clk_sys_i);
    seize_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    seize_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    seize_i <= 1'b1;
    repeat (Q_CYC + 4) @(posedge clk_sys_i);
    #1;
    chk("current after reseize", 8'h01, {7'h00, current});
    // Mid-run reset clears the taps and drops the line at once
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    seize_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk("tap seven mid reset", 8'h00, tap7);
    chk("current mid reset", 8'h00, {7'h00, current});
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(8'h33, 8'h00, "tap seven after reset");
    test_done();
  end
endmodule
